// >>> logic/rx_alarm_defs.svh
// Register indices, field positions and reset values of the alarm and temperature bank
`ifndef RX_ALARM_DEFS_SVH
`define RX_ALARM_DEFS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define IDX_ALM_CH5_CH4  8'h19
`define IDX_ALM_CH3_CH2  8'h1A
`define IDX_ALM_CH1_CH0  8'h1B
`define IDX_TEMP_INT     8'h1C
`define IDX_TEMP_FRAC    8'h1D
`define IDX_RSVD_LO      8'h1E
`define IDX_RSVD_HI      8'h1F
`define IDX_EVT_STATUS   8'h30
`define IDX_EVT_MASK     8'h31

// ==========================================================
// Alarm byte field positions
`define BIT_ODD_HIGH     7
`define BIT_ODD_LOW      6
`define BIT_EVEN_HIGH    3
`define BIT_EVEN_LOW     2

// ==========================================================
// Event register layout and reset values
`define EVT_W            13
`define EVT_TEMP_BIT     12
`define EVT_MASK_RST     13'h0000
`define EVT_STATUS_RST   13'h0000
`define TEMP_INT_RST     8'h00
`define TEMP_FRAC_RST    8'h00

`endif

// >>> logic/rx_alarm_pkg.sv
// Types shared by the alarm and temperature bank
package rx_alarm_pkg;

	// ==========================================================
	// Register selection
	typedef enum logic [3:0] {
		sel_alm_ch5_ch4,
		sel_alm_ch3_ch2,
		sel_alm_ch1_ch0,
		sel_temp_int,
		sel_temp_frac,
		sel_reserved,
		sel_evt_status,
		sel_evt_mask,
		sel_none
	} reg_sel_e;

	typedef logic [7:0] byte_t;

endpackage

// >>> logic/alarm_flag.sv
// One latched alarm flag, cleared by a read, set wins over clear
`include "rx_alarm_defs.svh"

module alarm_flag (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Condition and clear
	input  wire logic cond,
	input  wire logic clear,
	// Flag
	output logic      flag,
	output logic      set_event
);

	logic next_flag;

	// ==========================================================
	// Latch
	always_comb begin
		next_flag = cond | (flag & ~clear);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag <= 1'b0;
		end else begin
			flag <= next_flag;
		end
	end

	// New latching only; a held alarm raises no second event
	assign set_event = cond & ~flag;

	// ==========================================================
	// Checks
	a_cond_sets: assert property (@(posedge pclk) disable iff (!presetn)
		cond |=> flag)
		else $error("alarm condition did not latch");

	a_flag_holds: assert property (@(posedge pclk) disable iff (!presetn)
		(flag && !clear) |=> flag)
		else $error("latched alarm dropped without a read");

	a_clear_drops: assert property (@(posedge pclk) disable iff (!presetn)
		(clear && !cond) |=> !flag)
		else $error("alarm not cleared by read");

endmodule

// >>> logic/temp_capture.sv
// Coherent capture of the temperature integer and fraction pair
`include "rx_alarm_defs.svh"

module temp_capture (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Monitor sample
	input  wire logic        valid,
	input  wire logic [7:0]  int_in,
	input  wire logic [7:0]  frac_in,
	// Held value
	output logic [7:0]       int_q,
	output logic [7:0]       frac_q
);

	logic [7:0] next_int;
	logic [7:0] next_frac;

	// ==========================================================
	// Both bytes move together so the held pair never mixes two samples
	always_comb begin
		next_int  = int_q;
		next_frac = frac_q;
		if (valid) begin
			next_int  = int_in;
			next_frac = frac_in;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_q  <= `TEMP_INT_RST;
			frac_q <= `TEMP_FRAC_RST;
		end else begin
			int_q  <= next_int;
			frac_q <= next_frac;
		end
	end

	// ==========================================================
	// Checks
	a_pair_taken: assert property (@(posedge pclk) disable iff (!presetn)
		valid |=> (int_q == $past(int_in)) && (frac_q == $past(frac_in)))
		else $error("temperature pair not captured");

	a_pair_held: assert property (@(posedge pclk) disable iff (!presetn)
		!valid |=> $stable(int_q) && $stable(frac_q))
		else $error("temperature changed without a sample");

endmodule

// >>> logic/rx_power_alarm_status_bank.sv
// APB bank of latched receive power alarms, temperature bytes and event interrupt
`include "rx_alarm_defs.svh"

module rx_power_alarm_status_bank #(
	parameter int CHANNELS = 6,
	parameter int PADDR_W  = 10
) (
	// Clock and reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	// APB slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [PADDR_W-1:0]  paddr,
	input  wire logic [31:0]         pwdata,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	// Power comparators, one bit per channel
	input  wire logic [CHANNELS-1:0] rx_power_high,
	input  wire logic [CHANNELS-1:0] rx_power_low,
	// Temperature monitor
	input  wire logic                temp_valid,
	input  wire logic [7:0]          temp_integer_in,
	input  wire logic [7:0]          temp_fraction_in,
	// Interrupt
	output logic                     irq
);

	// ==========================================================
	// Declarations
	rx_alarm_pkg::reg_sel_e  sel;
	logic [CHANNELS-1:0]     hi_flag;
	logic [CHANNELS-1:0]     lo_flag;
	logic [CHANNELS-1:0]     hi_event;
	logic [CHANNELS-1:0]     lo_event;
	logic [CHANNELS-1:0]     hi_clear;
	logic [CHANNELS-1:0]     lo_clear;
	logic [CHANNELS-1:0]     clr_hi_mask;
	logic [CHANNELS-1:0]     clr_lo_mask;
	logic [CHANNELS-1:0]     next_clr_hi_mask;
	logic [CHANNELS-1:0]     next_clr_lo_mask;
	logic [31:0]             next_prdata;
	logic                    next_pslverr;
	logic [`EVT_W-1:0]       evt_status;
	logic [`EVT_W-1:0]       evt_mask;
	logic [`EVT_W-1:0]       next_evt_status;
	logic [`EVT_W-1:0]       next_evt_mask;
	logic [`EVT_W-1:0]       evt_set;
	logic [7:0]              temp_int_q;
	logic [7:0]              temp_frac_q;
	logic                    setup;
	logic                    access;
	logic                    rd_setup;
	logic                    wr_access;
	rx_alarm_pkg::byte_t     rd_byte;

	// ==========================================================
	// Alarm byte assembly
	function automatic rx_alarm_pkg::byte_t alarm_byte(
		input logic hi_odd,
		input logic lo_odd,
		input logic hi_even,
		input logic lo_even
	);
		rx_alarm_pkg::byte_t b;
		b                 = 8'h00;
		b[`BIT_ODD_HIGH]  = hi_odd;
		b[`BIT_ODD_LOW]   = lo_odd;
		b[`BIT_EVEN_HIGH] = hi_even;
		b[`BIT_EVEN_LOW]  = lo_even;
		return b;
	endfunction

	// ==========================================================
	// Per channel latches
	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
			alarm_flag u_high (
				.pclk      (pclk),
				.presetn   (presetn),
				.cond      (rx_power_high[ch]),
				.clear     (hi_clear[ch]),
				.flag      (hi_flag[ch]),
				.set_event (hi_event[ch])
			);
			alarm_flag u_low (
				.pclk      (pclk),
				.presetn   (presetn),
				.cond      (rx_power_low[ch]),
				.clear     (lo_clear[ch]),
				.flag      (lo_flag[ch]),
				.set_event (lo_event[ch])
			);
		end
	endgenerate

	// ==========================================================
	// Temperature
	temp_capture u_temp (
		.pclk    (pclk),
		.presetn (presetn),
		.valid   (temp_valid),
		.int_in  (temp_integer_in),
		.frac_in (temp_fraction_in),
		.int_q   (temp_int_q),
		.frac_q  (temp_frac_q)
	);

	// ==========================================================
	// Bus phases; every access completes in one cycle
	assign pready    = 1'b1;
	assign setup     = psel & ~penable;
	assign access    = psel & penable;
	assign rd_setup  = setup & ~pwrite;
	assign wr_access = access & pwrite;

	// ==========================================================
	// Address decode
	always_comb begin
		if (paddr[1:0] != 2'b00) begin
			sel = rx_alarm_pkg::sel_none;
		end else if (paddr[9:2] == `IDX_ALM_CH5_CH4) begin
			sel = rx_alarm_pkg::sel_alm_ch5_ch4;
		end else if (paddr[9:2] == `IDX_ALM_CH3_CH2) begin
			sel = rx_alarm_pkg::sel_alm_ch3_ch2;
		end else if (paddr[9:2] == `IDX_ALM_CH1_CH0) begin
			sel = rx_alarm_pkg::sel_alm_ch1_ch0;
		end else if (paddr[9:2] == `IDX_TEMP_INT) begin
			sel = rx_alarm_pkg::sel_temp_int;
		end else if (paddr[9:2] == `IDX_TEMP_FRAC) begin
			sel = rx_alarm_pkg::sel_temp_frac;
		end else if (paddr[9:2] == `IDX_RSVD_LO || paddr[9:2] == `IDX_RSVD_HI) begin
			sel = rx_alarm_pkg::sel_reserved;
		end else if (paddr[9:2] == `IDX_EVT_STATUS) begin
			sel = rx_alarm_pkg::sel_evt_status;
		end else if (paddr[9:2] == `IDX_EVT_MASK) begin
			sel = rx_alarm_pkg::sel_evt_mask;
		end else begin
			sel = rx_alarm_pkg::sel_none;
		end
	end

	// ==========================================================
	// Read data, taken at setup so prdata comes from a flop
	always_comb begin
		rd_byte          = 8'h00;
		next_clr_hi_mask = clr_hi_mask;
		next_clr_lo_mask = clr_lo_mask;
		next_prdata      = prdata;
		next_pslverr     = pslverr;
		if (setup) begin
			next_clr_hi_mask = '0;
			next_clr_lo_mask = '0;
			next_pslverr     = (sel == rx_alarm_pkg::sel_none);
		end
		if (rd_setup) begin
			case (sel)
				rx_alarm_pkg::sel_alm_ch5_ch4: begin
					rd_byte = alarm_byte(hi_flag[5], lo_flag[5], hi_flag[4], lo_flag[4]);
					next_clr_hi_mask[5] = hi_flag[5];
					next_clr_lo_mask[5] = lo_flag[5];
					next_clr_hi_mask[4] = hi_flag[4];
					next_clr_lo_mask[4] = lo_flag[4];
				end
				rx_alarm_pkg::sel_alm_ch3_ch2: begin
					rd_byte = alarm_byte(hi_flag[3], lo_flag[3], hi_flag[2], lo_flag[2]);
					next_clr_hi_mask[3] = hi_flag[3];
					next_clr_lo_mask[3] = lo_flag[3];
					next_clr_hi_mask[2] = hi_flag[2];
					next_clr_lo_mask[2] = lo_flag[2];
				end
				rx_alarm_pkg::sel_alm_ch1_ch0: begin
					rd_byte = alarm_byte(hi_flag[1], lo_flag[1], hi_flag[0], lo_flag[0]);
					next_clr_hi_mask[1] = hi_flag[1];
					next_clr_lo_mask[1] = lo_flag[1];
					next_clr_hi_mask[0] = hi_flag[0];
					next_clr_lo_mask[0] = lo_flag[0];
				end
				rx_alarm_pkg::sel_temp_int: begin
					rd_byte = temp_int_q;
				end
				rx_alarm_pkg::sel_temp_frac: begin
					rd_byte = temp_frac_q;
				end
				default: begin
					rd_byte = 8'h00;
				end
			endcase
			next_prdata = {24'h000000, rd_byte};
			if (sel == rx_alarm_pkg::sel_evt_status) begin
				next_prdata = {{(32-`EVT_W){1'b0}}, evt_status};
			end else if (sel == rx_alarm_pkg::sel_evt_mask) begin
				next_prdata = {{(32-`EVT_W){1'b0}}, evt_mask};
			end
		end
	end

	// Only bits actually returned are cleared, so a set arriving mid-transfer survives
	assign hi_clear = (access && !pwrite) ? clr_hi_mask : '0;
	assign lo_clear = (access && !pwrite) ? clr_lo_mask : '0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata      <= 32'h00000000;
			pslverr     <= 1'b0;
			clr_hi_mask <= '0;
			clr_lo_mask <= '0;
		end else begin
			prdata      <= next_prdata;
			pslverr     <= next_pslverr;
			clr_hi_mask <= next_clr_hi_mask;
			clr_lo_mask <= next_clr_lo_mask;
		end
	end

	// ==========================================================
	// Event status, mask and interrupt
	assign evt_set = {temp_valid, lo_event, hi_event};

	always_comb begin
		next_evt_status = evt_status;
		next_evt_mask   = evt_mask;
		if (wr_access && sel == rx_alarm_pkg::sel_evt_status) begin
			next_evt_status = evt_status & ~pwdata[`EVT_W-1:0];
		end
		if (wr_access && sel == rx_alarm_pkg::sel_evt_mask) begin
			next_evt_mask = pwdata[`EVT_W-1:0];
		end
		// Set wins over a same-cycle clear
		next_evt_status = next_evt_status | evt_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_status <= `EVT_STATUS_RST;
			evt_mask   <= `EVT_MASK_RST;
		end else begin
			evt_status <= next_evt_status;
			evt_mask   <= next_evt_mask;
		end
	end

	assign irq = |(evt_status & evt_mask);

	// ==========================================================
	// Checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_ch4_high_read: assert property (
		(rd_setup && paddr[9:2] == `IDX_ALM_CH5_CH4 && paddr[1:0] == 2'b00)
		|=> prdata[`BIT_EVEN_HIGH] == $past(hi_flag[4]))
		else $error("byte 25 bit 3 not channel 4 high");

	a_ch4_high_clear: assert property (
		(rd_setup && paddr[9:2] == `IDX_ALM_CH5_CH4 && paddr[1:0] == 2'b00 && hi_flag[4])
		##1 (access && !rx_power_high[4]) |=> !hi_flag[4])
		else $error("channel 4 high not cleared by read");

	a_ch4_low_read: assert property (
		(rd_setup && paddr[9:2] == `IDX_ALM_CH5_CH4 && paddr[1:0] == 2'b00)
		|=> prdata[`BIT_EVEN_LOW] == $past(lo_flag[4]))
		else $error("byte 25 bit 2 not channel 4 low");

	a_ch3_pair_read: assert property (
		(rd_setup && paddr[9:2] == `IDX_ALM_CH3_CH2 && paddr[1:0] == 2'b00)
		|=> prdata[`BIT_ODD_HIGH:`BIT_ODD_LOW] == $past({hi_flag[3], lo_flag[3]}))
		else $error("byte 26 bits 7:6 not channel 3");

	a_ch2_pair_read: assert property (
		(rd_setup && paddr[9:2] == `IDX_ALM_CH3_CH2 && paddr[1:0] == 2'b00)
		|=> prdata[`BIT_EVEN_HIGH:`BIT_EVEN_LOW] == $past({hi_flag[2], lo_flag[2]}))
		else $error("byte 26 bits 3:2 not channel 2");

	a_ch1_pair_read: assert property (
		(rd_setup && paddr[9:2] == `IDX_ALM_CH1_CH0 && paddr[1:0] == 2'b00)
		|=> prdata[`BIT_ODD_HIGH:`BIT_ODD_LOW] == $past({hi_flag[1], lo_flag[1]}))
		else $error("byte 27 bits 7:6 not channel 1");

	a_ch0_pair_read: assert property (
		(rd_setup && paddr[9:2] == `IDX_ALM_CH1_CH0 && paddr[1:0] == 2'b00)
		|=> prdata[`BIT_EVEN_HIGH:`BIT_EVEN_LOW] == $past({hi_flag[0], lo_flag[0]}))
		else $error("byte 27 bits 3:2 not channel 0");

	a_temp_int_read: assert property (
		(rd_setup && paddr[9:2] == `IDX_TEMP_INT && paddr[1:0] == 2'b00)
		|=> prdata == {24'h000000, $past(temp_int_q)})
		else $error("byte 28 not temperature integer");

	a_temp_frac_read: assert property (
		(rd_setup && paddr[9:2] == `IDX_TEMP_FRAC && paddr[1:0] == 2'b00)
		|=> prdata == {24'h000000, $past(temp_frac_q)})
		else $error("byte 29 not temperature fraction");

	a_ch5_high_read: assert property (
		(rd_setup && paddr[9:2] == `IDX_ALM_CH5_CH4 && paddr[1:0] == 2'b00)
		|=> prdata[`BIT_ODD_HIGH] == $past(hi_flag[5]))
		else $error("byte 25 bit 7 not channel 5 high");

	a_relatch_read: assert property (
		(access && !pwrite && clr_lo_mask[3] && rx_power_low[3]) |=> lo_flag[3])
		else $error("held low alarm lost on read");

	a_reserved_zero: assert property (
		(rd_setup && paddr[9:2] >= `IDX_ALM_CH5_CH4 && paddr[9:2] <= `IDX_ALM_CH1_CH0)
		|=> prdata[31:8] == 24'h000000 && prdata[5:4] == 2'b00 && prdata[1:0] == 2'b00)
		else $error("reserved alarm bits not zero");

	a_rsvd_reg_zero: assert property (
		(rd_setup && sel == rx_alarm_pkg::sel_reserved) |=> prdata == 32'h00000000)
		else $error("reserved register not zero");

	a_ch5_low_read: assert property (
		(rd_setup && paddr[9:2] == `IDX_ALM_CH5_CH4 && paddr[1:0] == 2'b00)
		|=> prdata[`BIT_ODD_LOW] == $past(lo_flag[5]))
		else $error("byte 25 bit 6 not channel 5 low");

	a_error_flag: assert property (
		setup |=> pslverr == $past(sel == rx_alarm_pkg::sel_none))
		else $error("error response does not match decode");

	a_irq_follows: assert property (
		(evt_set[`EVT_TEMP_BIT] && evt_mask[`EVT_TEMP_BIT]
			&& !(wr_access && sel == rx_alarm_pkg::sel_evt_mask)) |=> irq)
		else $error("masked-in event gave no interrupt");

	// A clearing write in the same cycle must not swallow a new event
	a_set_wins: assert property (
		(evt_set != '0) |=> (evt_status & $past(evt_set)) == $past(evt_set))
		else $error("event lost to a same-cycle clear");

	a_mask_write: assert property (
		(wr_access && sel == rx_alarm_pkg::sel_evt_mask) |=> evt_mask == $past(pwdata[`EVT_W-1:0]))
		else $error("mask write not taken");

endmodule

// >>> tb/rx_power_alarm_status_bank_tb.sv
// Self-checking bench for the alarm and temperature register bank
`include "rx_alarm_defs.svh"

module rx_power_alarm_status_bank_tb;
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================================
	// Signals
	typedef struct packed {
		logic        wr;
		logic        err;
		logic [31:0] data;
	} exp_s;

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [9:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [5:0]  rx_power_high;
	logic [5:0]  rx_power_low;
	logic        temp_valid;
	logic [7:0]  temp_integer_in;
	logic [7:0]  temp_fraction_in;
	logic        irq;
	exp_s        notes[$];
	exp_s        cur;
	int          errors;
	int          cmp_count;
	int          n;
	logic [7:0]  t_int;
	logic [7:0]  t_frac;
	logic [5:0]  hi_v;
	logic [5:0]  lo_v;

	rx_power_alarm_status_bank #(.CHANNELS(6), .PADDR_W(10)) i_rx_power_alarm_status_bank (
		.pclk             (pclk),
		.presetn          (presetn),
		.psel             (psel),
		.penable          (penable),
		.pwrite           (pwrite),
		.paddr            (paddr),
		.pwdata           (pwdata),
		.prdata           (prdata),
		.pready           (pready),
		.pslverr          (pslverr),
		.rx_power_high    (rx_power_high),
		.rx_power_low     (rx_power_low),
		.temp_valid       (temp_valid),
		.temp_integer_in  (temp_integer_in),
		.temp_fraction_in (temp_fraction_in),
		.irq              (irq)
	);

	initial pclk = 1'h0;
	always #25 pclk = ~pclk;

	// ==========================================================
	// Reporting
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		cmp_count++;
		if (seen !== want) begin
			errors++;
			$display("unexpected at %0t ns: seen %h, expected %h", $time, seen, want);
		end
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d, errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ==========================================================
	// APB master; the expectation is noted before the transfer starts
	task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d,
			input logic err, input logic [31:0] want);
		int k;
		notes.push_back('{wr, err, want});
		@(posedge pclk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'h1;
		k = 0;
		// No wait limit here; only the watchdog ends a hung transfer
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'h1);
		check(k, 32'h1);
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask

	function automatic logic [9:0] adr(input logic [7:0] idx);
		return {idx, 2'h0};
	endfunction

	task automatic rd(input logic [7:0] idx, input logic [31:0] want);
		apb(1'h0, adr(idx), 32'h0, 1'h0, want);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		apb(1'h1, adr(idx), d, 1'h0, 32'h0);
	endtask

	// Pair p holds the odd channel in the upper nibble
	function automatic logic [31:0] alarm_word(input logic [5:0] h, input logic [5:0] l,
			input int p);
		return {24'h0, h[2*p+1], l[2*p+1], 2'h0, h[2*p], l[2*p], 2'h0};
	endfunction

	task automatic read_alarms(input logic [5:0] h, input logic [5:0] l);
		for (int p = 0; p < 3; p++) begin
			rd(8'(`IDX_ALM_CH1_CH0 - p), alarm_word(h, l, p));
		end
	endtask

	// One-cycle comparator pulse, short on purpose to prove the latch
	task automatic cond(input logic [5:0] h, input logic [5:0] l);
		@(posedge pclk);
		rx_power_high <= h;
		rx_power_low  <= l;
		@(posedge pclk);
		rx_power_high <= 6'h0;
		rx_power_low  <= 6'h0;
	endtask

	task automatic irq_is(input logic v);
		@(negedge pclk);
		check({31'h0, irq}, {31'h0, v});
	endtask

	task automatic irq_wait;
		n = 0;
		while (irq !== 1'h1 && n < 8) begin
			@(negedge pclk);
			n++;
		end
		irq_is(1'h1);
	endtask

	// ==========================================================
	// Monitor: every completed transfer consumes the oldest note
	always @(posedge pclk) begin
		if (psel === 1'h1 && penable === 1'h1 && pready === 1'h1) begin
			if (notes.size() == 0) begin
				errors++;
				$display("unexpected at %0t ns: transfer without a note", $time);
			end else begin
				cur = notes.pop_front();
				check({31'h0, pslverr}, {31'h0, cur.err});
				if (cur.wr === 1'h0) check(prdata, cur.data);
			end
		end
	end

	// Whole run is well under a thousand cycles
	initial begin
		#(50 * 5000);
		errors++;
		tally_and_finish();
	end

	// ==========================================================
	// Main sequence
	initial begin
		presetn          = 1'h0;
		psel             = 1'h0;
		penable          = 1'h0;
		pwrite           = 1'h0;
		paddr            = 10'h0;
		pwdata           = 32'h0;
		rx_power_high    = 6'h0;
		rx_power_low     = 6'h0;
		temp_valid       = 1'h0;
		temp_integer_in  = 8'h0;
		temp_fraction_in = 8'h0;
		errors           = 0;
		cmp_count        = 0;
		void'($urandom(82));
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		read_alarms(6'h0, 6'h0);
		rd(`IDX_TEMP_INT, 32'h0);
		rd(`IDX_TEMP_FRAC, 32'h0);
		rd(`IDX_EVT_STATUS, 32'h0);
		rd(`IDX_EVT_MASK, 32'h0);
		// Each flag alone, then gone after one read
		for (int c = 0; c < 12; c++) begin
			hi_v = (c < 6) ? 6'(1 << c) : 6'h0;
			lo_v = (c >= 6) ? 6'(1 << (c - 6)) : 6'h0;
			cond(hi_v, lo_v);
			read_alarms(hi_v, lo_v);
			read_alarms(6'h0, 6'h0);
		end
		repeat (4) begin
			hi_v = 6'($urandom);
			lo_v = 6'($urandom);
			cond(hi_v, lo_v);
			read_alarms(hi_v, lo_v);
			read_alarms(6'h0, 6'h0);
		end
		// Condition still present across clearing reads
		@(posedge pclk);
		rx_power_low <= 6'h08;
		@(posedge pclk);
		rd(`IDX_ALM_CH3_CH2, 32'h40);
		rd(`IDX_ALM_CH3_CH2, 32'h40);
		@(posedge pclk);
		rx_power_low <= 6'h0;
		rd(`IDX_ALM_CH3_CH2, 32'h40);
		rd(`IDX_ALM_CH3_CH2, 32'h0);
		// Temperature pair, inputs scrambled after the capture
		t_int  = 8'($urandom);
		t_frac = 8'($urandom);
		@(posedge pclk);
		temp_valid       <= 1'h1;
		temp_integer_in  <= t_int;
		temp_fraction_in <= t_frac;
		@(posedge pclk);
		temp_valid       <= 1'h0;
		temp_integer_in  <= ~t_int;
		temp_fraction_in <= ~t_frac;
		rd(`IDX_TEMP_INT, {24'h0, t_int});
		rd(`IDX_TEMP_FRAC, {24'h0, t_frac});
		wr(`IDX_TEMP_INT, 32'hFF);
		wr(`IDX_TEMP_FRAC, 32'hFF);
		rd(`IDX_TEMP_INT, {24'h0, t_int});
		rd(`IDX_TEMP_FRAC, {24'h0, t_frac});
		// Reserved, unmapped and misaligned places
		rd(`IDX_RSVD_LO, 32'h0);
		rd(`IDX_RSVD_HI, 32'h0);
		apb(1'h0, 10'h200, 32'h0, 1'h1, 32'h0);
		apb(1'h0, 10'h071, 32'h0, 1'h1, 32'h0);
		apb(1'h1, 10'h200, 32'hFFFF, 1'h1, 32'h0);
		// Interrupt: raise, mask, clear
		wr(`IDX_EVT_STATUS, 32'h1FFF);
		rd(`IDX_EVT_STATUS, 32'h0);
		wr(`IDX_EVT_MASK, 32'h1);
		irq_is(1'h0);
		cond(6'h1, 6'h0);
		irq_wait();
		rd(`IDX_EVT_STATUS, 32'h1);
		wr(`IDX_EVT_MASK, 32'h0);
		irq_is(1'h0);
		wr(`IDX_EVT_MASK, 32'h1);
		irq_is(1'h1);
		wr(`IDX_EVT_STATUS, 32'h1);
		irq_is(1'h0);
		rd(`IDX_EVT_STATUS, 32'h0);
		rd(`IDX_ALM_CH1_CH0, 32'h8);
		wr(`IDX_EVT_MASK, 32'h1000);
		rd(`IDX_EVT_MASK, 32'h1000);
		@(posedge pclk);
		temp_valid <= 1'h1;
		@(posedge pclk);
		temp_valid <= 1'h0;
		irq_wait();
		wr(`IDX_EVT_STATUS, 32'h1000);
		irq_is(1'h0);
		// Reset in mid-run drops latched alarms, temperature and mask
		cond(6'h3F, 6'h3F);
		wr(`IDX_EVT_MASK, 32'h1FFF);
		irq_is(1'h1);
		@(posedge pclk);
		presetn <= 1'h0;
		irq_is(1'h0);
		check(prdata, 32'h0);
		@(posedge pclk);
		presetn <= 1'h1;
		read_alarms(6'h0, 6'h0);
		rd(`IDX_TEMP_INT, 32'h0);
		rd(`IDX_EVT_MASK, 32'h0);
		tally_and_finish();
	end

endmodule
